/* design/upfp_regs.svh */
`ifndef UPFP_REGS_SVH
`define UPFP_REGS_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define UPFP_A_CTRL 8'h00
`define UPFP_A_BAUD 8'h04
`define UPFP_A_PINS 8'h08
`define UPFP_A_STAT 8'h0C
`define UPFP_A_CRC 8'h10
`define UPFP_A_TOKEN 8'h14
// ---------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------
`define UPFP_FLUSH_DEF 8'h10
`define UPFP_FLUSH_MIN 8'h02
`define UPFP_BAUD_DEF 16'h0064
`define UPFP_PIN0_DEF 4'h4
`define UPFP_PIN1_DEF 4'h3
`define UPFP_BUF_DEPTH 512
`define UPFP_STAGE_DEPTH 16
`define UPFP_PKT_LEN 10'h040
`define UPFP_STUFF_RUN 3'h6
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define UPFP_CLK_MHZ 100
`define UPFP_MS_NS 1000000
`define UPFP_GAP_NS 80
`define UPFP_GAP_CYC (((`UPFP_GAP_NS * `UPFP_CLK_MHZ) + 999) / 1000)
`define UPFP_MS_CYC ((`UPFP_MS_NS / 1000) * `UPFP_CLK_MHZ)
`define UPFP_WAKE_MS 8'h14
// ---------------------------------------------------------------
// Serial engine constants
// ---------------------------------------------------------------
`define UPFP_CRC16_POLY 16'hA001
`define UPFP_CRC16_INIT 16'hFFFF
`define UPFP_CRC5_POLY 5'h14
`define UPFP_CRC5_INIT 5'h1F
`endif

/* design/upfp_pkg.sv */
package upfp_pkg;
  typedef enum logic [1:0] {
    UPFP_MODE_FIFO = 2'b00,
    UPFP_MODE_ABB = 2'b01,
    UPFP_MODE_SBB = 2'b10
  } upfp_mode_t;
  typedef enum logic [3:0] {
    UPFP_PIN_TRI = 4'b0000,
    UPFP_PIN_ONE = 4'b0001,
    UPFP_PIN_ZERO = 4'b0010,
    UPFP_PIN_PWREN = 4'b0011,
    UPFP_PIN_SLEEP = 4'b0100,
    UPFP_PIN_BBWR = 4'b0101,
    UPFP_PIN_BBRD = 4'b0110
  } upfp_pin_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } upfp_strm_t;
  typedef struct packed {
    logic [7:0] flush_ms;
    logic wake_en;
    upfp_mode_t mode;
  } upfp_ctrl_t;
endpackage

/* design/upfp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module upfp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH) + 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q, rptr_q;
  logic [CW-1:0] mcnt_q, mcnt_d;
  logic push, load;
  assign push = in_valid & in_ready;
  assign load = (mcnt_q != '0) & (~out_valid | out_ready);
  assign mcnt_d = mcnt_q + CW'(push) - CW'(load);
  assign count = mcnt_q + CW'(out_valid);
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      mcnt_q <= '0;
      in_ready <= 1'b0;
    end else begin
      wptr_q <= wptr_q + AW'(push);
      rptr_q <= rptr_q + AW'(load);
      mcnt_q <= mcnt_d;
      // Output stage is one slot, so memory holds DEPTH-1
      in_ready <= (mcnt_d < CW'(DEPTH - 1));
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data <= mem[rptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // upfp_fifo
`default_nettype wire

/* design/upfp_top.sv */
// Functional notes
// - Host OUT bytes sit in 512-byte rx buffer, one popped per read strobe.
// - External writes fill 512-byte tx buffer; host IN requests drain it.
// - FIFO controller moves bytes between buffers and eight data pins.
// - Flush timeout releases pending bytes; default 16 ms, 2..255 ms in 1 ms.
// - Async bit-bang drives host bytes to the pins at the baud timer rate.
// - Sync bit-bang samples pins only when a host byte is driven out.
// - Wake pin low 20 ms during suspend with wake enabled requests resume.
// - Remote wake is enabled after reset and software may clear it.
// - Two control pins each carry one selected function, with defaults.
// - One core clock runs serial engine, protocol side and FIFO controller.
// - A derived timer from the core clock paces the bit-bang baud rate.
// - Serial engine keeps CRC16 of sent bytes, CRC5 of token, unstuffing.
// - Incoming NRZI line is decoded into bits for the serial engine.
// - Reset input clears all internal logic asynchronously except the buffer memory arrays.
// - Rx flag goes inactive at least 80 ns after each completed read.
// - Tx flag goes inactive at least 80 ns after each completed write.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "upfp_regs.svh"
module upfp_top import upfp_pkg::*; #(
  parameter int MS_CYCLES = `UPFP_MS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic rx_byte_avail_n,
  output logic tx_space_avail_n,
  input wire logic wake_request_n,
  output logic [1:0] ctrl_pin_o,
  output logic [1:0] ctrl_pin_oe_n,
  input wire upfp_strm_t host_out,
  output logic host_out_ready,
  output upfp_strm_t host_in,
  input wire logic host_in_ready,
  input wire logic host_suspend,
  output logic resume_req,
  input wire logic usb_line_i
);
  localparam int GAP = `UPFP_GAP_CYC;
  localparam int BW = 10;
  upfp_ctrl_t ctrl_q;
  logic [15:0] baud_q, crc16_q;
  logic [3:0] pin_sel_q [2];
  logic [10:0] token_q;
  logic [4:0] crc5_q;
  logic rd_prev_q, wr_prev_q, rd_rise, rd_fall, wr_rise;
  logic [7:0] wr_data_q;
  logic [3:0] rx_gap_q, tx_gap_q;
  logic rx_vld, rx_rdy, tx_in_vld, tx_in_rdy, tx_vld, tx_rdy;
  logic [7:0] rx_dat, tx_dat, sp_dat;
  logic [BW-1:0] rx_cnt, tx_cnt;
  logic sp_in_vld, sp_in_rdy, sp_vld, sp_rdy;
  logic [15:0] baud_cnt_q;
  logic bb_tick, bb_out, bb_wr_q, bb_rd_q;
  logic [31:0] ms_cnt_q;
  logic ms_tick, rel_q;
  logic [7:0] flush_cnt_q, wake_cnt_q;
  logic src_vld, src_take;
  logic [7:0] src_dat;
  logic line_prev_q, stuff_err_q;
  logic [2:0] ones_q;
  logic [15:0] bits_q;
  logic setup;
  logic [7:0] wr_flush;
  logic [31:0] rdata_d;
  upfp_mode_t mode;
  assign mode = ctrl_q.mode;

  // -------------------------------------------------------------
  // CRC helpers
  // -------------------------------------------------------------
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `UPFP_CRC16_POLY) : (r >> 1);
    end
    return r;
  endfunction
  function automatic logic [4:0] crc5_tok(input logic [10:0] t);
    logic [4:0] r;
    r = `UPFP_CRC5_INIT;
    for (int i = 0; i < 11; i++) begin
      r = (r[0] ^ t[i]) ? ((r >> 1) ^ `UPFP_CRC5_POLY) : (r >> 1);
    end
    return ~r;
  endfunction

  // -------------------------------------------------------------
  // APB slave
  // -------------------------------------------------------------
  assign setup = psel & ~penable;
  assign wr_flush = (pwdata[15:8] < `UPFP_FLUSH_MIN) ? `UPFP_FLUSH_MIN : pwdata[15:8];
  always_comb begin
    rdata_d = '0;
    if (paddr == `UPFP_A_CTRL) begin
      rdata_d = {16'h0000, ctrl_q.flush_ms, 5'h00, ctrl_q.wake_en, ctrl_q.mode};
    end else if (paddr == `UPFP_A_BAUD) begin
      rdata_d = {16'h0000, baud_q};
    end else if (paddr == `UPFP_A_PINS) begin
      rdata_d = {24'h000000, pin_sel_q[1], pin_sel_q[0]};
    end else if (paddr == `UPFP_A_STAT) begin
      rdata_d = {stuff_err_q, resume_req, host_suspend, 3'h0, tx_cnt, 6'h00, rx_cnt};
    end else if (paddr == `UPFP_A_CRC) begin
      rdata_d = {11'h000, crc5_q, crc16_q};
    end else if (paddr == `UPFP_A_TOKEN) begin
      rdata_d = {bits_q, 5'h00, token_q};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      prdata <= setup ? rdata_d : 32'h00000000;
      pslverr <= setup & (paddr > `UPFP_A_TOKEN | paddr[1:0] != 2'h0);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '{flush_ms: `UPFP_FLUSH_DEF, wake_en: 1'b1, mode: UPFP_MODE_FIFO};
      baud_q <= `UPFP_BAUD_DEF;
      pin_sel_q[0] <= `UPFP_PIN0_DEF;
      pin_sel_q[1] <= `UPFP_PIN1_DEF;
      token_q <= '0;
    end else if (psel & penable & pready & pwrite) begin
      if (paddr == `UPFP_A_CTRL) begin
        ctrl_q <= '{flush_ms: wr_flush, wake_en: pwdata[2], mode: upfp_mode_t'(pwdata[1:0])};
      end else if (paddr == `UPFP_A_BAUD) begin
        baud_q <= pwdata[15:0];
      end else if (paddr == `UPFP_A_PINS) begin
        pin_sel_q[0] <= pwdata[3:0];
        pin_sel_q[1] <= pwdata[7:4];
      end else if (paddr == `UPFP_A_TOKEN) begin
        token_q <= pwdata[10:0];
      end
    end
  end

  // -------------------------------------------------------------
  // Buffers
  // -------------------------------------------------------------
  upfp_fifo #(.W(8), .DEPTH(`UPFP_BUF_DEPTH), .CW(BW)) u_rx_buf (
    .clk(pclk), .rst_n(presetn),
    .in_valid(host_out.valid), .in_data(host_out.data), .in_ready(host_out_ready),
    .out_valid(rx_vld), .out_data(rx_dat), .out_ready(rx_rdy), .count(rx_cnt)
  );
  upfp_fifo #(.W(8), .DEPTH(`UPFP_BUF_DEPTH), .CW(BW)) u_tx_buf (
    .clk(pclk), .rst_n(presetn),
    .in_valid(tx_in_vld), .in_data(wr_data_q), .in_ready(tx_in_rdy),
    .out_valid(tx_vld), .out_data(tx_dat), .out_ready(tx_rdy), .count(tx_cnt)
  );
  upfp_fifo #(.W(8), .DEPTH(`UPFP_STAGE_DEPTH)) u_sample_buf (
    .clk(pclk), .rst_n(presetn),
    .in_valid(sp_in_vld), .in_data(data_i), .in_ready(sp_in_rdy),
    .out_valid(sp_vld), .out_data(sp_dat), .out_ready(sp_rdy), .count()
  );

  // -------------------------------------------------------------
  // Strobes and FIFO controller
  // -------------------------------------------------------------
  assign rd_rise = rd_n & ~rd_prev_q;
  assign rd_fall = ~rd_n & rd_prev_q;
  assign wr_rise = wr_n & ~wr_prev_q;
  assign tx_in_vld = wr_rise & (mode == UPFP_MODE_FIFO);
  assign sp_in_vld = bb_out & (mode == UPFP_MODE_SBB);
  // Sync mode stalls output until a sample slot is free
  assign bb_out = bb_tick & rx_vld & (mode != UPFP_MODE_FIFO)
                  & (sp_in_rdy | mode == UPFP_MODE_ABB);
  assign rx_rdy = (mode == UPFP_MODE_FIFO) ? rd_rise : bb_out;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      wr_data_q <= '0;
    end else begin
      rd_prev_q <= rd_n;
      wr_prev_q <= wr_n;
      if (!wr_n) begin
        wr_data_q <= data_i;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_o <= '0;
      data_oe_n <= 1'b1;
    end else if (mode == UPFP_MODE_FIFO) begin
      data_oe_n <= rd_n;
      if (rd_fall) begin
        data_o <= rx_dat;
      end
    end else begin
      data_oe_n <= 1'b0;
      if (bb_out) begin
        data_o <= rx_dat;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_gap_q <= '0;
      rx_byte_avail_n <= 1'b1;
    end else begin
      rx_gap_q <= rd_rise ? 4'(GAP) : (rx_gap_q != '0) ? rx_gap_q - 4'h1 : rx_gap_q;
      rx_byte_avail_n <= ~(mode == UPFP_MODE_FIFO & rx_vld & rx_gap_q == '0 & ~rd_rise);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_gap_q <= '0;
      tx_space_avail_n <= 1'b1;
    end else begin
      tx_gap_q <= wr_rise ? 4'(GAP) : (tx_gap_q != '0) ? tx_gap_q - 4'h1 : tx_gap_q;
      tx_space_avail_n <= ~(mode == UPFP_MODE_FIFO & tx_in_rdy & tx_gap_q == '0 & ~wr_rise);
    end
  end

  // -------------------------------------------------------------
  // Timers
  // -------------------------------------------------------------
  assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));
  assign bb_tick = (baud_cnt_q == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_q <= '0;
      baud_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
      baud_cnt_q <= bb_tick ? baud_q : baud_cnt_q - 16'h0001;
    end
  end

  // -------------------------------------------------------------
  // Host IN path with flush timeout
  // -------------------------------------------------------------
  assign src_vld = (mode == UPFP_MODE_SBB) ? sp_vld : (tx_vld & rel_q);
  assign src_dat = (mode == UPFP_MODE_SBB) ? sp_dat : tx_dat;
  assign src_take = src_vld & (~host_in.valid | host_in_ready);
  assign tx_rdy = src_take & (mode != UPFP_MODE_SBB);
  assign sp_rdy = src_take & (mode == UPFP_MODE_SBB);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_q <= 1'b0;
      flush_cnt_q <= '0;
    end else begin
      if (tx_cnt == '0 | tx_in_vld) begin
        flush_cnt_q <= '0;
      end else if (ms_tick & ~rel_q) begin
        flush_cnt_q <= flush_cnt_q + 8'h01;
      end
      if (tx_cnt == '0) begin
        rel_q <= 1'b0;
      end else if (tx_cnt >= `UPFP_PKT_LEN | flush_cnt_q >= ctrl_q.flush_ms) begin
        rel_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_in <= '0;
      crc16_q <= `UPFP_CRC16_INIT;
    end else begin
      if (src_take) begin
        host_in <= '{valid: 1'b1, data: src_dat};
        crc16_q <= crc16_byte(crc16_q, src_dat);
      end else if (host_in_ready) begin
        host_in.valid <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // Serial engine receive side
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev_q <= 1'b1;
      ones_q <= '0;
      bits_q <= '0;
      stuff_err_q <= 1'b0;
      crc5_q <= '0;
    end else begin
      line_prev_q <= usb_line_i;
      crc5_q <= crc5_tok(token_q);
      // No transition decodes to one, a transition to zero
      if (ones_q == `UPFP_STUFF_RUN) begin
        ones_q <= '0;
        stuff_err_q <= stuff_err_q | (usb_line_i == line_prev_q);
      end else if (usb_line_i == line_prev_q) begin
        ones_q <= ones_q + 3'h1;
        bits_q <= {1'b1, bits_q[15:1]};
      end else begin
        ones_q <= '0;
        bits_q <= {1'b0, bits_q[15:1]};
      end
    end
  end

  // -------------------------------------------------------------
  // Wake request and control pins
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_q <= '0;
      resume_req <= 1'b0;
    end else begin
      if (wake_request_n | ~host_suspend) begin
        wake_cnt_q <= '0;
      end else if (ms_tick & wake_cnt_q != `UPFP_WAKE_MS) begin
        wake_cnt_q <= wake_cnt_q + 8'h01;
      end
      if (~host_suspend) begin
        resume_req <= 1'b0;
      end else if (wake_cnt_q == `UPFP_WAKE_MS & ctrl_q.wake_en) begin
        resume_req <= 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bb_wr_q <= 1'b1;
      bb_rd_q <= 1'b1;
      ctrl_pin_o <= '0;
      ctrl_pin_oe_n <= '1;
    end else begin
      bb_wr_q <= ~bb_out;
      bb_rd_q <= ~sp_in_vld;
      for (int i = 0; i < 2; i++) begin
        ctrl_pin_oe_n[i] <= (pin_sel_q[i] == UPFP_PIN_TRI);
        case (pin_sel_q[i])
          UPFP_PIN_ONE: ctrl_pin_o[i] <= 1'b1;
          UPFP_PIN_PWREN: ctrl_pin_o[i] <= host_suspend;
          UPFP_PIN_SLEEP: ctrl_pin_o[i] <= ~host_suspend;
          UPFP_PIN_BBWR: ctrl_pin_o[i] <= bb_wr_q;
          UPFP_PIN_BBRD: ctrl_pin_o[i] <= bb_rd_q;
          default: ctrl_pin_o[i] <= 1'b0;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rx_gap_hold: assert property (rd_rise |=> rx_byte_avail_n [*8])
    else $error("rx flag back too soon after read");
  a_tx_gap_hold: assert property (wr_rise |=> tx_space_avail_n [*8])
    else $error("tx flag back too soon after write");
  a_rx_flag_data: assert property (!rx_byte_avail_n |-> $past(rx_vld))
    else $error("rx flag without data");
  a_rx_pop_count: assert property (rd_rise && rx_vld && !(host_out.valid && host_out_ready)
      && mode == UPFP_MODE_FIFO |=> rx_cnt == $past(rx_cnt) - 10'h001)
    else $error("read did not remove a byte");
  a_flush_range: assert property (ctrl_q.flush_ms >= `UPFP_FLUSH_MIN)
    else $error("flush timeout below minimum");
  a_abb_drive: assert property (bb_out && mode == UPFP_MODE_ABB
      |=> data_o == $past(rx_dat) && !data_oe_n)
    else $error("bit-bang byte not driven");
  a_wake_cause: assert property ($rose(resume_req)
      |-> $past(ctrl_q.wake_en && host_suspend && !wake_request_n))
    else $error("resume without qualified wake");
  a_wake_default: assert property (@(posedge pclk) disable iff (1'b0)
      $rose(presetn) |-> ctrl_q.wake_en)
    else $error("remote wake not enabled after reset");
  a_pin_zero: assert property (pin_sel_q[0] == UPFP_PIN_ZERO
      |=> !ctrl_pin_o[0] && !ctrl_pin_oe_n[0])
    else $error("control pin not driven low");
  c_fifo_read: cover property (rd_rise && rx_vld);
  c_flush_release: cover property ($rose(rel_q) && tx_cnt < `UPFP_PKT_LEN);
  c_resume: cover property ($rose(resume_req));
endmodule // upfp_top
`default_nettype wire

/* dv/upfp_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// External byte-bus master model
// ------------------------------
module upfp_mcu_model (
  input wire logic clk,
  input wire logic rx_byte_avail_n,
  input wire logic tx_space_avail_n,
  input wire logic [7:0] data_o,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] data_i,
  output logic got_v,
  output logic [7:0] got_b,
  output logic stuck
);
  logic drv;
  logic [7:0] wb;
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_i = 8'hFF;
    got_v = 1'b0;
    got_b = 8'h00;
    stuck = 1'b0;
    drv = 1'b0;
    wb = 8'h00;
  end
  // Released bus floats high on the pin pull-ups
  always @(posedge clk) data_i <= drv ? wb : 8'hFF;
  task automatic read_byte(input int slow);
    int n;
    n = 0;
    while (rx_byte_avail_n !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    stuck <= stuck | (n == 3000);
    rd_n <= 1'b0;
    repeat (3 + slow) @(posedge clk);
    got_b <= data_o;
    got_v <= 1'b1;
    rd_n <= 1'b1;
    @(posedge clk);
    got_v <= 1'b0;
    // Flag seen at this edge is stale; let the gap show first
    @(posedge clk);
  endtask
  task automatic write_byte(input logic [7:0] b);
    int n;
    n = 0;
    while (tx_space_avail_n !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    stuck <= stuck | (n == 3000);
    wb <= b;
    drv <= 1'b1;
    wr_n <= 1'b0;
    repeat (3) @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
    drv <= 1'b0;
    @(posedge clk);
  endtask
  task automatic hold_bus(input logic en, input logic [7:0] b);
    wb <= b;
    drv <= en;
  endtask
endmodule // upfp_mcu_model
`default_nettype wire

/* dv/tb_usb_parallel_fifo_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "upfp_regs.svh"
module tb_usb_parallel_fifo_port import upfp_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, data_oe_n;
  logic [7:0] paddr, data_i, data_o, got_b;
  logic [31:0] pwdata, prdata, r;
  logic rd_n, wr_n, rx_byte_avail_n, tx_space_avail_n, wake_request_n, e;
  logic [1:0] ctrl_pin_o, ctrl_pin_oe_n;
  upfp_strm_t host_out, host_in;
  logic host_out_ready, host_in_ready, host_suspend, resume_req, got_v, stuck, take_en, usb_line;
  logic [7:0] exp_rx[$], exp_tx[$], b;
  int failures, tests_run, seed, k, n, rx_gap, tx_gap;
  upfp_top #(.MS_CYCLES(20)) upfp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .data_i(data_i), .data_o(data_o),
    .data_oe_n(data_oe_n), .rd_n(rd_n), .wr_n(wr_n), .rx_byte_avail_n(rx_byte_avail_n),
    .tx_space_avail_n(tx_space_avail_n), .wake_request_n(wake_request_n),
    .ctrl_pin_o(ctrl_pin_o), .ctrl_pin_oe_n(ctrl_pin_oe_n), .host_out(host_out),
    .host_out_ready(host_out_ready), .host_in(host_in), .host_in_ready(host_in_ready),
    .host_suspend(host_suspend), .resume_req(resume_req), .usb_line_i(usb_line));
  upfp_mcu_model upfp_mcu_model_inst (.clk(pclk), .rx_byte_avail_n(rx_byte_avail_n),
    .tx_space_avail_n(tx_space_avail_n), .data_o(data_o), .rd_n(rd_n), .wr_n(wr_n),
    .data_i(data_i), .got_v(got_v), .got_b(got_b), .stuck(stuck));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (x !== g) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, x, g);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    r = prdata;
    e = pslverr;
    if (t == 50) begin
      failures++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check("register read", x, r);
  endtask
  task automatic push_rx(input int cnt);
    int t;
    for (int i = 0; i < cnt; i++) begin
      b = 8'($random(seed));
      host_out <= '{valid: 1'b1, data: b};
      t = 0;
      do begin
        @(posedge pclk);
        t++;
      end while (host_out_ready !== 1'b1 && t < 100);
      if (t == 100) begin
        failures++;
        close_out();
      end
      exp_rx.push_back(b);
    end
    host_out <= '0;
  endtask
  task automatic wait_empty(input int lim);
    n = 0;
    while ((exp_rx.size() + exp_tx.size()) != 0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check("queues drained", 0, exp_rx.size() + exp_tx.size());
  endtask
  // ---------------------
  // Result watchers
  // ---------------------
  always @(posedge pclk) begin
    host_in_ready <= take_en & 1'($random(seed));
    usb_line <= ~usb_line;
    if (got_v) check("rx byte", exp_rx.size() ? exp_rx.pop_front() : 'x, got_b);
    if (host_in.valid && host_in_ready) begin
      check("tx byte", exp_tx.size() ? exp_tx.pop_front() : 'x, host_in.data);
    end
    rx_gap <= rx_byte_avail_n ? rx_gap + 1 : 0;
    tx_gap <= tx_space_avail_n ? tx_gap + 1 : 0;
    if (!rx_byte_avail_n && rx_gap != 0) check("rx gap", 1, rx_gap >= `UPFP_GAP_CYC);
    if (!tx_space_avail_n && tx_gap != 0) check("tx gap", 1, tx_gap >= `UPFP_GAP_CYC);
  end
  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    close_out();
  end
  // ---------------------
  // Main sequence
  // ---------------------
  initial begin
    seed = 14;
    {presetn, psel, penable, pwrite, paddr, pwdata, host_out, host_suspend, take_en} = '0;
    {host_in_ready, usb_line, rx_gap, tx_gap, failures, tests_run} = '0;
    wake_request_n = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(`UPFP_A_CTRL, 32'h0000_1004);
    rd(`UPFP_A_BAUD, 32'h0000_0064);
    rd(`UPFP_A_PINS, 32'h0000_0034);
    check("ctrl pins", 32'h1, {30'h0, ctrl_pin_o});
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped error", 32'h1, {31'h0, e});
    $display("test reset values done");
    push_rx(512);
    repeat (4) @(posedge pclk);
    check("rx full refuses", 32'h0, {31'h0, host_out_ready});
    for (k = 0; k < 512; k++) upfp_mcu_model_inst.read_byte(k % 3);
    wait_empty(100);
    check("rx flag empty", 32'h1, {31'h0, rx_byte_avail_n});
    $display("test rx buffer done");
    take_en <= 1'b1;
    for (k = 0; k < 70; k++) begin
      b = 8'($random(seed));
      exp_tx.push_back(b);
      upfp_mcu_model_inst.write_byte(b);
    end
    wait_empty(3000);
    $display("test tx buffer done");
    apb(1'b1, `UPFP_A_CTRL, 32'h0000_0104);
    rd(`UPFP_A_CTRL, 32'h0000_0204);
    take_en <= 1'b0;
    for (k = 0; k < 3; k++) begin
      exp_tx.push_back(8'hC0 + 8'(k));
      upfp_mcu_model_inst.write_byte(8'hC0 + 8'(k));
    end
    repeat (15) @(posedge pclk);
    check("flush early", 32'h0, {31'h0, host_in.valid});
    take_en <= 1'b1;
    wait_empty(300);
    $display("test flush done");
    for (k = 0; k < 2; k++) begin
      apb(1'b1, `UPFP_A_CTRL, k ? 32'h0000_0200 : 32'h0000_0204);
      host_suspend <= 1'b1;
      repeat (3) @(posedge pclk);
      check("suspend pins", 32'h2, {30'h0, ctrl_pin_o});
      wake_request_n <= 1'b0;
      repeat (300) @(posedge pclk);
      check("wake early", 32'h0, {31'h0, resume_req});
      repeat (150) @(posedge pclk);
      check("wake resume", {31'h0, !k}, {31'h0, resume_req});
      wake_request_n <= 1'b1;
      host_suspend <= 1'b0;
      repeat (3) @(posedge pclk);
      check("resume drop", 32'h0, {31'h0, resume_req});
    end
    $display("test wake done");
    apb(1'b1, `UPFP_A_PINS, 32'h0000_0012);
    @(posedge pclk);
    check("pins forced", 32'h2, {30'h0, ctrl_pin_o});
    check("pins driven", 32'h0, {30'h0, ctrl_pin_oe_n});
    apb(1'b1, `UPFP_A_PINS, 32'h0000_0000);
    @(posedge pclk);
    check("pins tri", 32'h3, {30'h0, ctrl_pin_oe_n});
    $display("test control pins done");
    apb(1'b1, `UPFP_A_BAUD, 32'h0000_0003);
    apb(1'b1, `UPFP_A_CTRL, 32'h0000_1005);
    push_rx(2);
    for (k = 0; k < 2; k++) begin
      n = 0;
      while (data_o !== exp_rx[k] && n < 100) begin
        @(posedge pclk);
        n++;
      end
      check("bit-bang byte", exp_rx[k], data_o);
      check("bit-bang drive", 32'h0, {31'h0, data_oe_n});
    end
    exp_rx.delete();
    $display("test async bit-bang done");
    apb(1'b1, `UPFP_A_CTRL, 32'h0000_1006);
    upfp_mcu_model_inst.hold_bus(1'b1, 8'h3C);
    exp_tx.push_back(8'h3C);
    exp_tx.push_back(8'h3C);
    push_rx(2);
    exp_rx.delete();
    wait_empty(200);
    upfp_mcu_model_inst.hold_bus(1'b0, 8'h00);
    rd(`UPFP_A_TOKEN, 32'h0000_0000);
    rd(`UPFP_A_STAT, 32'h0000_0000);
    $display("test sync bit-bang done");
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    check("reset flags", 32'h3, {30'h0, rx_byte_avail_n, tx_space_avail_n});
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(`UPFP_A_CTRL, 32'h0000_1004);
    check("model stalls", 32'h0, {31'h0, stuck});
    $display("test mid-run reset done");
    close_out();
  end
endmodule // tb_usb_parallel_fifo_port
`default_nettype wire
